// ===== hw/radio_tx_cca_timer_event_flags.sv
// radio_tx_cca_timer_event_flags: event flags 15..23 of the transceiver with their timing,
// an axi4-lite register slave, sticky status, mask and one level interrupt.
// assumes RX_SYNC_LOST and CCA_BUSY come from logic on CLK; AWADDR/ARADDR are byte addresses.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module radio_tx_cca_timer_event_flags
    import evt_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYC,
    parameter int AD_SLOW_CYCLES = AD_SLOW_CYC
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [9:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [9:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic RX_SYNC_LOST,
    input wire logic CCA_BUSY,
    output logic IRQ
);
    evt_state_type st, next_st;
    logic [23:0] ev, clr;
    logic [31:0] bm, rd;
    logic [15:0] bp, new_len;
    logic [12:0] ad_lim;
    logic [19:0] tx_total;
    logic [7:0] dv;
    logic do_wr, wr_ok, rd_ok, inc, dec, fifo_wr, len_wr, tx_on, cca_go;
    logic bit_tick, ad_tick, base_tick, gt_tick, pull, judge;
    logic [1:0] gt_start, gt_done;

    // whole next state: bus slave, registers, tx sequencer, cca sequencer, flags
    always_comb begin
        next_st = st;
        ev = '0;
        clr = '0;
        rd = '0;
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        inc = 1'b0;
        dec = 1'b0;
        fifo_wr = 1'b0;
        len_wr = 1'b0;
        tx_on = 1'b0;
        cca_go = 1'b0;
        gt_start = 2'b00;
        bm = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        new_len = {st.tx_len[15:8], st.wdata[7:0]};
        bp = (st.bit_period == 16'h0000) ? 16'h0001 : st.bit_period;
        ad_lim = st.ad_sel[0] ? 13'(AD_FAST_CYC) : 13'(AD_SLOW_CYCLES);
        dv = (st.gt_div == 8'h00) ? 8'h01 : st.gt_div;
        tx_total = {1'b0, st.tx_len, 3'b000} + TAIL_BITS;
        bit_tick = (st.tx_ph == TX_BITS) && (st.bit_div >= bp - 16'h0001);
        ad_tick = (st.cca_ph != CCA_IDLE) && (st.ad_div >= ad_lim - 13'h0001);
        base_tick = (st.gt_base >= 8'(GT_CLK_CYC - 1));
        gt_tick = base_tick && (st.gt_pre >= dv - 8'h01);
        pull = bit_tick && (st.tx_cnt[2:0] == 3'b000) && (st.tx_cnt < {1'b0, st.tx_len, 3'b000});
        judge = (st.cca_ph == CCA_AVG) && ad_tick
            && ({8'h00, st.cca_avg} <= st.cca_cnt + 16'h0001);
        do_wr = st.aw_got && st.w_got && !st.bvalid;

        // write address and data are taken independently
        if (AWVALID && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_idx = AWADDR[9:2];
            next_st.awready = 1'b0;
        end
        if (WVALID && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = WDATA;
            next_st.wstrb = WSTRB;
            next_st.wready = 1'b0;
        end
        if (st.bvalid && BREADY) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // register write decode
        if (do_wr) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            case (st.aw_idx)
                IDX_AD_SEL: if (st.wstrb[0]) next_st.ad_sel = st.wdata[7:0];
                IDX_RX_PIN: if (st.wstrb[0]) next_st.rx_pin = st.wdata[7:0];
                IDX_GT_DIV: if (st.wstrb[0]) next_st.gt_div = st.wdata[7:0];
                IDX_GT1: if (st.wstrb[0]) next_st.gt1_int = st.wdata[7:0];
                IDX_GT2: if (st.wstrb[0]) next_st.gt2_int = st.wdata[7:0];
                IDX_IDLE_HI: if (st.wstrb[0]) next_st.idle_wait[15:8] = st.wdata[7:0];
                IDX_IDLE_LO: if (st.wstrb[0]) next_st.idle_wait[7:0] = st.wdata[7:0];
                IDX_LEN_HI: if (st.wstrb[0]) next_st.tx_len[15:8] = st.wdata[7:0];
                IDX_LEN_LO: begin
                    if (st.wstrb[0]) begin
                        len_wr = 1'b1;
                        next_st.tx_len = new_len;
                        // zero or oversize length is still stored, but raises the length error flag
                        ev[EV_LEN_ERR] = (new_len == 16'h0000) || (new_len > TX_LEN_MAX);
                    end
                end
                IDX_STATUS: clr = st.wdata[23:0] & bm[23:0];
                IDX_MASK: next_st.mask = (st.mask & ~bm[23:0]) | (st.wdata[23:0] & bm[23:0]);
                IDX_COMMAND: begin
                    if (st.wstrb[0]) begin
                        tx_on = st.wdata[CMD_TX_ON];
                        cca_go = st.wdata[CMD_CCA_START];
                        gt_start = st.wdata[CMD_GT_START +: 2];
                    end
                end
                IDX_CCA_CFG: begin
                    if (st.wstrb[0]) next_st.cca_avg = st.wdata[7:0];
                    if (st.wstrb[1]) next_st.cca_mode = st.wdata[CCA_MODE_BIT];
                end
                IDX_CCA_RESULT: wr_ok = 1'b1; // read only, write ignored
                IDX_BIT_PERIOD: begin
                    next_st.bit_period = (st.bit_period & ~bm[15:0]) | (st.wdata[15:0] & bm[15:0]);
                end
                IDX_FIFO_DATA: fifo_wr = st.wstrb[0];
                default: wr_ok = 1'b0;
            endcase
            next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        // host fifo write: refused when a packet waits or the fifo is full
        if (fifo_wr) begin
            if (st.pkt_full) begin
                ev[EV_FIFO_ERR] = 1'b1;
            end else if (st.fifo_level == FIFO_DEPTH) begin
                ev[EV_FIFO_ERR] = 1'b1;
            end else begin
                inc = 1'b1;
                next_st.wr_count = st.wr_count + 16'h0001;
                if (st.wr_count + 16'h0001 == st.tx_len) begin
                    ev[EV_TX_ACCEPT] = 1'b1;
                    next_st.pkt_full = 1'b1;
                end
            end
        end

        // register read mux
        case (ARADDR[9:2])
            IDX_AD_SEL: rd = {24'h000000, st.ad_sel};
            IDX_RX_PIN: rd = {24'h000000, st.rx_pin};
            IDX_GT_DIV: rd = {24'h000000, st.gt_div};
            IDX_GT1: rd = {24'h000000, st.gt1_int};
            IDX_GT2: rd = {24'h000000, st.gt2_int};
            IDX_IDLE_HI: rd = {24'h000000, st.idle_wait[15:8]};
            IDX_IDLE_LO: rd = {24'h000000, st.idle_wait[7:0]};
            IDX_LEN_HI: rd = {24'h000000, st.tx_len[15:8]};
            IDX_LEN_LO: rd = {24'h000000, st.tx_len[7:0]};
            IDX_STATUS: rd = {8'h00, st.status};
            IDX_MASK: rd = {8'h00, st.mask};
            IDX_COMMAND: rd = {24'h000000, 6'h00, st.cca_ph != CCA_IDLE, st.tx_ph != TX_IDLE};
            IDX_CCA_CFG: rd = {23'h000000, st.cca_mode, st.cca_avg};
            IDX_CCA_RESULT: rd = {31'h00000000, st.cca_result};
            IDX_BIT_PERIOD: rd = {16'h0000, st.bit_period};
            IDX_FIFO_DATA: rd = {25'h0000000, st.fifo_level};
            default: rd_ok = 1'b0;
        endcase
        if (ARVALID && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && RREADY) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // tx sequencer: wake-up, then data bits plus tail, pulling a byte per 8 bits
        unique case (st.tx_ph)
            TX_IDLE: begin
                if (tx_on) begin
                    next_st.tx_ph = TX_WAKE;
                    next_st.tx_cnt = 20'h00000;
                end
            end
            TX_WAKE: begin
                next_st.tx_cnt = st.tx_cnt + 20'h00001;
                if (st.tx_cnt >= 20'(WAKE_CYCLES - 1)) begin
                    next_st.tx_ph = TX_BITS;
                    next_st.tx_cnt = 20'h00000;
                    next_st.bit_div = 16'h0000;
                end
            end
            TX_BITS: begin
                next_st.bit_div = st.bit_div + 16'h0001;
                if (bit_tick) begin
                    next_st.bit_div = 16'h0000;
                    next_st.tx_cnt = st.tx_cnt + 20'h00001;
                    if (pull) begin
                        if (st.fifo_level == 7'h00) begin
                            ev[EV_FIFO_ERR] = 1'b1;
                        end else begin
                            dec = 1'b1;
                        end
                    end
                    if (st.tx_cnt >= tx_total - 20'h00001) begin
                        ev[EV_TX_DONE] = 1'b1;
                        next_st.tx_ph = TX_IDLE;
                        next_st.pkt_full = 1'b0;
                        next_st.wr_count = 16'h0000;
                    end
                end
            end
            default: next_st.tx_ph = TX_IDLE;
        endcase
        next_st.fifo_level = st.fifo_level + {6'h00, inc} - {6'h00, dec};

        // clearing the cca flag drops its result; a new result below still wins
        if (clr[EV_CCA_DONE]) next_st.cca_result = 1'b0;

        // cca sequencer counting ad conversions
        unique case (st.cca_ph)
            CCA_IDLE: begin
                if (cca_go) begin
                    next_st.cca_ph = CCA_AVG;
                    next_st.cca_cnt = 16'h0000;
                    next_st.ad_div = 13'h0000;
                end
            end
            CCA_AVG, CCA_WAIT: begin
                next_st.ad_div = ad_tick ? 13'h0000 : st.ad_div + 13'h0001;
                if (ad_tick) next_st.cca_cnt = st.cca_cnt + 16'h0001;
                if (judge) begin
                    next_st.cca_result = CCA_BUSY;
                    if ((st.cca_mode && CCA_BUSY) || st.idle_wait == 16'h0000) begin
                        ev[EV_CCA_DONE] = 1'b1;
                        next_st.cca_ph = CCA_IDLE;
                    end else begin
                        next_st.cca_ph = CCA_WAIT;
                        next_st.cca_cnt = 16'h0000;
                    end
                end else if (st.cca_ph == CCA_WAIT && ad_tick
                        && st.idle_wait <= st.cca_cnt + 16'h0001) begin
                    ev[EV_CCA_DONE] = 1'b1;
                    next_st.cca_ph = CCA_IDLE;
                end
            end
            default: next_st.cca_ph = CCA_IDLE;
        endcase

        // shared timer prescaler
        next_st.gt_base = base_tick ? 8'h00 : st.gt_base + 8'h01;
        if (base_tick) next_st.gt_pre = gt_tick ? 8'h00 : st.gt_pre + 8'h01;

        // sync loss and timer events
        ev[EV_SYNC_ERR] = RX_SYNC_LOST && (st.rx_pin[PIN_SEL_LO +: 2] == PIN_SEL_A
            || st.rx_pin[PIN_SEL_LO +: 2] == PIN_SEL_B);
        ev[EV_GT1 +: 2] = gt_done;

        // sticky flags, set wins over clear, masked causes still recorded
        next_st.status = ((st.status & ~clr) | ev) & EV_VALID;
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // state register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.bit_period <= BIT_PERIOD_RST;
        end else begin
            st <= next_st;
        end
    end

    // two general-purpose timers on the shared prescaler
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            gp_interval_timer u_timer (
                .clk(CLK),
                .arst_n(ARST_N),
                .start(gt_start[gi]),
                .tick(gt_tick),
                .interval(gi == 0 ? st.gt1_int : st.gt2_int),
                .done(gt_done[gi])
            );
        end
    endgenerate

    // outputs straight from the state register
    assign AWREADY = st.awready;
    assign WREADY = st.wready;
    assign BVALID = st.bvalid;
    assign BRESP = st.bresp;
    assign ARREADY = st.arready;
    assign RVALID = st.rvalid;
    assign RDATA = st.rdata;
    assign RRESP = st.rresp;
    assign IRQ = st.irq;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_last_bit;
        (st.tx_ph == TX_BITS) && bit_tick && (st.tx_cnt == tx_total - 20'h00001);
    endsequence
    sequence s_judge_busy;
        judge && st.cca_mode && CCA_BUSY;
    endsequence

    sync_err_flag_a: assert property (RX_SYNC_LOST && ev[EV_SYNC_ERR] |=> st.status[EV_SYNC_ERR])
        else $error("sync error not flagged");
    sync_err_gate_a: assert property (!ev[EV_SYNC_ERR] && !st.status[EV_SYNC_ERR]
        && st.rx_pin[PIN_SEL_LO +: 2] == 2'h1 |=> !st.status[EV_SYNC_ERR])
        else $error("sync error flagged with wrong pin function");
    wake_delay_a: assert property (st.tx_ph == TX_WAKE && st.tx_cnt == 20'(WAKE_CYCLES - 1)
        |=> st.tx_ph == TX_BITS && st.tx_cnt == 20'h00000)
        else $error("wake-up delay length wrong");
    tx_done_flag_a: assert property (s_last_bit |=> st.status[EV_TX_DONE] && st.tx_ph == TX_IDLE)
        else $error("tx completion not flagged after tail bits");
    tx_accept_a: assert property (fifo_wr && !st.pkt_full && st.fifo_level != FIFO_DEPTH
        && st.wr_count + 16'h0001 == st.tx_len |=> st.status[EV_TX_ACCEPT] && st.pkt_full)
        else $error("packet acceptance not flagged");
    cca_busy_end_a: assert property (s_judge_busy |=> st.cca_ph == CCA_IDLE
        && st.status[EV_CCA_DONE] && st.cca_result)
        else $error("busy cca did not end after averaging");
    cca_idle_wait_a: assert property (judge && !CCA_BUSY && st.idle_wait != 16'h0000
        |=> st.cca_ph == CCA_WAIT && st.cca_cnt == 16'h0000)
        else $error("idle cca skipped the idle wait");
    ad_period_a: assert property (ad_tick |=> st.ad_div == 13'h0000 ##1 !ad_tick [*7])
        else $error("conversion period too short");
    len_err_flag_a: assert property (len_wr && new_len == 16'h0000 |=> st.status[EV_LEN_ERR])
        else $error("zero length not flagged");
    fifo_next_pkt_a: assert property (fifo_wr && st.pkt_full |=> st.status[EV_FIFO_ERR])
        else $error("write into pending packet not flagged");
    fifo_under_a: assert property (pull && st.fifo_level == 7'h00 |=> st.status[EV_FIFO_ERR])
        else $error("underflow not flagged");
    irq_follows_a: assert property (IRQ == (|(st.status & st.mask)))
        else $error("interrupt does not follow unmasked flags");
    cca_result_drop_a: assert property (clr[EV_CCA_DONE] && !judge |=> !st.cca_result)
        else $error("cca result kept after flag clear");
    flag_hold_a: assert property (st.status[EV_TX_DONE] && !clr[EV_TX_DONE]
        |=> st.status[EV_TX_DONE])
        else $error("tx completion flag dropped without clear");
    rsvd_zero_a: assert property (!st.status[EV_RSVD])
        else $error("reserved flag set");
endmodule : radio_tx_cca_timer_event_flags

// ===== hw/evt_pkg.sv
// evt_pkg: constants, register map and state types of the tx/cca/timer event flags.
// assumes one 250 MHz core clock; register indices are word indices on the bus.
package evt_pkg;
    // clock and timing
    localparam int CLK_NS = 4;
    localparam int WAKE_NS = 210000;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int AD_SLOW_NS = 17700;
    localparam int AD_SLOW_CYC = (AD_SLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int AD_FAST_NS = 16000;
    localparam int AD_FAST_CYC = (AD_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int GT_CLK_NS = 1000;
    localparam int GT_CLK_CYC = (GT_CLK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [19:0] TAIL_BITS = 20'h00003;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [15:0] TX_LEN_MAX = 16'h00FF;
    localparam logic [15:0] BIT_PERIOD_RST = 16'h09C4;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_AD_SEL = 8'h08;
    localparam logic [7:0] IDX_RX_PIN = 8'h0C;
    localparam logic [7:0] IDX_GT_DIV = 8'h33;
    localparam logic [7:0] IDX_GT1 = 8'h34;
    localparam logic [7:0] IDX_GT2 = 8'h35;
    localparam logic [7:0] IDX_IDLE_HI = 8'h3B;
    localparam logic [7:0] IDX_IDLE_LO = 8'h3C;
    localparam logic [7:0] IDX_LEN_HI = 8'h7A;
    localparam logic [7:0] IDX_LEN_LO = 8'h7B;
    localparam logic [7:0] IDX_STATUS = 8'h80;
    localparam logic [7:0] IDX_MASK = 8'h81;
    localparam logic [7:0] IDX_COMMAND = 8'h82;
    localparam logic [7:0] IDX_CCA_CFG = 8'h83;
    localparam logic [7:0] IDX_CCA_RESULT = 8'h84;
    localparam logic [7:0] IDX_BIT_PERIOD = 8'h85;
    localparam logic [7:0] IDX_FIFO_DATA = 8'h86;
    // event bit positions
    localparam int EV_SYNC_ERR = 15;
    localparam int EV_TX_DONE = 16;
    localparam int EV_TX_ACCEPT = 17;
    localparam int EV_CCA_DONE = 18;
    localparam int EV_LEN_ERR = 19;
    localparam int EV_FIFO_ERR = 20;
    localparam int EV_RSVD = 21;
    localparam int EV_GT1 = 22;
    localparam logic [23:0] EV_VALID = 24'hDF8000;
    // field positions and codes
    localparam int PIN_SEL_LO = 6;
    localparam logic [1:0] PIN_SEL_A = 2'h0;
    localparam logic [1:0] PIN_SEL_B = 2'h3;
    localparam int CMD_TX_ON = 0;
    localparam int CMD_CCA_START = 1;
    localparam int CMD_GT_START = 2;
    localparam int CCA_MODE_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAKE = 2'b01, TX_BITS = 2'b10} tx_phase_type;
    typedef enum logic [1:0] {CCA_IDLE = 2'b00, CCA_AVG = 2'b01, CCA_WAIT = 2'b10} cca_phase_type;

    typedef struct packed {
        logic run;
        logic [7:0] cnt;
        logic done;
    } gpt_state_type;

    typedef struct packed {
        logic awready, wready, bvalid, arready, rvalid, irq;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata, wdata;
        logic aw_got, w_got;
        logic [7:0] aw_idx;
        logic [3:0] wstrb;
        logic [7:0] rx_pin, ad_sel, gt_div, gt1_int, gt2_int, cca_avg;
        logic cca_mode, cca_result, pkt_full;
        logic [15:0] idle_wait, tx_len, bit_period, wr_count, bit_div, cca_cnt;
        logic [23:0] status, mask;
        logic [6:0] fifo_level;
        tx_phase_type tx_ph;
        logic [19:0] tx_cnt;
        cca_phase_type cca_ph;
        logic [12:0] ad_div;
        logic [7:0] gt_base, gt_pre;
    } evt_state_type;
endpackage : evt_pkg

// ===== hw/gp_interval_timer.sv
// gp_interval_timer: one general-purpose interval timer counting prescaled ticks.
// assumes tick is a one-cycle enable from the shared divider in the same clock domain.
module gp_interval_timer
    import evt_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic [7:0] interval,
    output logic done
);
    gpt_state_type st, next_st;
    logic reached;

    // count ticks from start until the interval is reached
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        reached = ({1'b0, st.cnt} + 9'h001) >= {1'b0, interval};
        if (start) begin
            next_st.run = 1'b1;
            next_st.cnt = 8'h00;
        end else if (st.run && tick) begin
            if (reached) begin
                next_st.run = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    timer_expiry_a: assert property (st.run && tick && reached && !start |=> done && !st.run)
        else $error("timer did not expire at its interval");
    timer_start_a: assert property (start |=> st.run && st.cnt == 8'h00 && !done)
        else $error("timer start did not restart the count");
endmodule : gp_interval_timer

// ===== verif/host_model.sv
// host_model: axi4-lite master standing in for the host processor.
// assumes the slave answers; a hang is cut by the bench timeout.
module host_model (
    input wire logic CLK,
    output logic [9:0] AWADDR, ARADDR,
    output logic [31:0] WDATA,
    output logic [3:0] WSTRB,
    output logic AWVALID, WVALID, BREADY, ARVALID, RREADY,
    input wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID,
    input wire logic [1:0] BRESP, RRESP,
    input wire logic [31:0] RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] bresp_seen;
    initial begin
        {AWADDR, ARADDR, WDATA, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
        WSTRB = 4'hF;
    end
    // one write: aw and w offered together, each released at its own handshake edge;
    // ready levels are looked at mid-cycle, where they stand for the coming edge
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        @(posedge CLK);
        AWADDR <= {idx, 2'h0};
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        fork
            begin
                @(negedge CLK);
                while (AWREADY !== 1'b1) @(negedge CLK);
                @(posedge CLK);
                AWVALID <= 1'b0;
            end
            begin
                @(negedge CLK);
                while (WREADY !== 1'b1) @(negedge CLK);
                @(posedge CLK);
                WVALID <= 1'b0;
            end
        join
        @(negedge CLK);
        while (BVALID !== 1'b1) @(negedge CLK);
        bresp_seen = BRESP;
        @(posedge CLK);
        BREADY <= 1'b0;
    endtask : wr
    // one read, data taken while rvalid stands before its handshake edge
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        ARADDR <= {idx, 2'h0};
        {ARVALID, RREADY} <= 2'h3;
        @(negedge CLK);
        while (ARREADY !== 1'b1) @(negedge CLK);
        @(posedge CLK);
        ARVALID <= 1'b0;
        @(negedge CLK);
        while (RVALID !== 1'b1) @(negedge CLK);
        d = RDATA;
        r = RRESP;
        @(posedge CLK);
        RREADY <= 1'b0;
    endtask : rd
endmodule : host_model

// ===== verif/tb.sv
// tb: scenario tests of the event flags through the register bus.
// assumes host_model drives the bus; short wake and slow conversion counts.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import evt_pkg::*;
    logic CLK = 0, ARST_N = 0, RX_SYNC_LOST = 0, CCA_BUSY = 0, AWVALID, WVALID, BREADY;
    logic ARVALID, RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    logic [9:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, v;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, r;
    int err_total = 0, tests_run = 0, cyc = 0;
    radio_tx_cca_timer_event_flags #(.WAKE_CYCLES(20), .AD_SLOW_CYCLES(12)) DUT (.*);
    host_model host (.*);
    initial forever #2 CLK = ~CLK;
    // cycle ceiling against hangs
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] s, e);
        tests_run = tests_run + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic st(input logic [31:0] e);
        host.rd(IDX_STATUS, v, r);
        chk(v, e);
    endtask : st
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task automatic t_reset();
        host.rd(IDX_BIT_PERIOD, v, r);
        chk(v, 32'h000009C4);
        host.rd(8'h10, v, r);
        chk(v, 32'h00000000);
        chk(r, RESP_SLVERR);
        host.wr(8'h10, 32'h00000001);
        chk(host.bresp_seen, RESP_SLVERR);
        $display("test reset done");
    endtask : t_reset
    task automatic t_sync();
        // sync loss counted only for pin codes 00 and 11
        host.wr(IDX_RX_PIN, 32'h40);
        @(posedge CLK) RX_SYNC_LOST <= 1;
        @(posedge CLK) RX_SYNC_LOST <= 0;
        st(0);
        host.wr(IDX_RX_PIN, 32'hC0);
        @(posedge CLK) RX_SYNC_LOST <= 1;
        @(posedge CLK) RX_SYNC_LOST <= 0;
        st(32'h8000);
        chk(IRQ, 0);
        host.wr(IDX_MASK, 32'h8000);
        chk(IRQ, 1);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        st(0);
        $display("test sync done");
    endtask : t_sync
    task automatic t_fifo();
        // zero length is flagged, two bytes fill the packet, a third is an error
        host.wr(IDX_LEN_LO, 0);
        st(32'h80000);
        host.wr(IDX_LEN_LO, 2);
        host.wr(IDX_BIT_PERIOD, 2);
        host.wr(IDX_FIFO_DATA, 32'hA5);
        host.wr(IDX_FIFO_DATA, 32'h5A);
        st(32'hA0000);
        host.wr(IDX_FIFO_DATA, 32'h11);
        st(32'h1A0000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        $display("test fifo done");
    endtask : t_fifo
    task automatic t_tx();
        // tx done at 20 + (16 + 3) * 2 + 1 edges after tx on
        host.wr(IDX_COMMAND, 1);
        repeat (45) @(posedge CLK);
        st(0);
        repeat (20) @(posedge CLK);
        st(32'h10000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        // 100-byte packet: the 65th write overflows, the send then runs dry
        host.wr(IDX_LEN_LO, 32'h00000064);
        repeat (65) host.wr(IDX_FIFO_DATA, 32'h000000C3);
        st(32'h00100000);
        host.rd(IDX_FIFO_DATA, v, r);
        chk(v, 32'h00000040);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        host.wr(IDX_COMMAND, 32'h00000001);
        repeat (1700) @(posedge CLK);
        st(32'h00110000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        $display("test tx done");
    endtask : t_tx
    task automatic t_cca();
        // one slow conversion with no idle wait
        host.wr(IDX_CCA_CFG, 1);
        host.wr(IDX_COMMAND, 2);
        repeat (30) @(posedge CLK);
        st(32'h40000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        // idle-detection mode, busy channel: two conversions, idle wait skipped
        CCA_BUSY <= 1'b1;
        host.wr(IDX_IDLE_LO, 32'h00000003);
        host.wr(IDX_CCA_CFG, 32'h00000102);
        host.wr(IDX_COMMAND, 32'h00000002);
        repeat (30) @(posedge CLK);
        st(32'h00040000);
        host.rd(IDX_CCA_RESULT, v, r);
        chk(v, 32'h00000001);
        host.wr(IDX_STATUS, 32'h00040000);
        host.rd(IDX_CCA_RESULT, v, r);
        chk(v, 32'h00000000);
        // idle channel: (2 + 3) conversions of 12 cycles
        CCA_BUSY <= 1'b0;
        host.wr(IDX_COMMAND, 32'h00000002);
        repeat (45) @(posedge CLK);
        st(32'h00000000);
        repeat (15) @(posedge CLK);
        st(32'h00040000);
        host.rd(IDX_CCA_RESULT, v, r);
        chk(v, 32'h00000000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        // fast ad clock: one conversion of 16 us, 4000 cycles
        host.wr(IDX_IDLE_LO, 32'h00000000);
        host.wr(IDX_CCA_CFG, 32'h00000001);
        host.wr(IDX_AD_SEL, 32'h00000001);
        host.wr(IDX_COMMAND, 32'h00000002);
        repeat (3990) @(posedge CLK);
        st(32'h00000000);
        repeat (10) @(posedge CLK);
        st(32'h00040000);
        host.wr(IDX_STATUS, 32'hFFFFFF);
        $display("test cca done");
    endtask : t_cca
    task automatic t_timer();
        // both timers, two ticks of 250 cycles, first may be partial
        host.wr(IDX_GT_DIV, 1);
        host.wr(IDX_GT1, 2);
        host.wr(IDX_GT2, 32'h00000002);
        host.wr(IDX_COMMAND, 32'h0000000C);
        repeat (200) @(posedge CLK);
        st(0);
        repeat (320) @(posedge CLK);
        st(32'hC00000);
        $display("test timer done");
    endtask : t_timer
    initial begin
        repeat (5) @(posedge CLK);
        ARST_N <= 1;
        t_reset();
        t_sync();
        t_fifo();
        t_tx();
        t_cca();
        t_timer();
        summarize();
    end
endmodule : tb
